// [shared/asptr_pkg.sv]
// Constants and carrier types for the timer-paced serial port.
// Assumes one 200 MHz clock and no software-reachable registers.
package asptr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MCLK_MHZ       = 200;
  localparam int MAX_RATE_BPS   = 62500;
  // Least bit period in clocks at the top rate
  localparam int MIN_BIT_CLKS   = (MCLK_MHZ * 1000000 + MAX_RATE_BPS - 1) / MAX_RATE_BPS;
  localparam int OVS            = 16;
  localparam int OVS_MID        = 7;
  localparam int PRESC_MAX      = 64;
  localparam int COUNT_MAX      = 256;
  localparam int DATA_BITS      = 8;
  localparam int TX_FRAME_BITS  = 11;
  localparam int PORT_IN_BIT    = 0;
  localparam int PORT_OUT_BIT   = 7;
  localparam logic RST_LINE     = 1'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ASPTR_RX_IDLE  = 2'h0,
    ASPTR_RX_START = 2'h1,
    ASPTR_RX_DATA  = 2'h3,
    ASPTR_RX_STOP  = 2'h2
  } asptr_rx_st_t;

  typedef struct packed {
    logic       serial_en;
    logic       parity_en;
    logic [5:0] presc_div_m1;
    logic [7:0] count_load_m1;
    logic       continuous;
  } asptr_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } asptr_byte_t;

endpackage

// [hdl/asptr_serial.sv]
// Timer-paced full-duplex serial port with tick generator and framer.
// Assumes cfg and tx request come from logic on mclk; the serial input is a pin.
`timescale 1ns/1ps
module asptr_serial
  import asptr_pkg::*;
#(
  // Least clocks between serial ticks; default keeps the top bit rate
  parameter int MIN_TICK_CLKS = MIN_BIT_CLKS / OVS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Configuration
  input  wire asptr_cfg_t  cfg,
  // Transmit side
  input  wire asptr_byte_t tx_req,
  output logic             tx_ready,
  // Receive side
  output asptr_byte_t      rx_byte,
  // Processor requests
  output logic             transmit_done_request,
  output logic             receive_done_request,
  // Control port lines
  input  wire logic [7:0]  port3_in,
  output logic [7:0]       port3_out,
  // Timer output
  output logic             bit_rate_timer
);

  typedef struct packed {
    logic [2:0]   sync;
    logic         line;
    logic [5:0]   presc;
    logic [7:0]   count;
    logic         tick;
    logic         tout;
    logic         halt;
    logic [15:0]  gap;
    logic [3:0]   tx_ovs;
    logic [3:0]   tx_bit;
    logic [10:0]  tx_sh;
    logic         tx_busy;
    logic         tx_o;
    logic         tx_done;
    asptr_rx_st_t rx_st;
    logic [3:0]   rx_ovs;
    logic [2:0]   rx_bit;
    logic [7:0]   rx_sh;
    asptr_byte_t  rx_out;
    logic         rx_done;
  } asptr_state_t;

  asptr_state_t s_q;
  asptr_state_t s_d;

  // Odd parity bit over seven data bits
  function automatic logic odd_par7(input logic [6:0] b);
    return ~(^b);
  endfunction

  // Floor must fit the sixteen-bit gap counter
  if (MIN_TICK_CLKS < 1 || MIN_TICK_CLKS > 65535) begin : g_floor_check
    $error("MIN_TICK_CLKS out of range");
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.tx_done = 1'b0;
    s_d.rx_done = 1'b0;
    s_d.rx_out.valid = 1'b0;
    // Three-stage sync; a change counts when stages two and three agree
    s_d.sync = {s_q.sync[1:0], port3_in[PORT_IN_BIT]};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.line = s_q.sync[2];
    end
    // Prescaler and down counter of timer zero; single pass halts at zero
    if (cfg.continuous) begin
      s_d.halt = 1'b0;
    end
    if (s_q.presc == 6'h00) begin
      s_d.presc = cfg.presc_div_m1;
      if (s_q.count == 8'h00) begin
        if (!s_q.halt) begin
          s_d.tout = ~s_q.tout;
          s_d.count = cfg.continuous ? cfg.count_load_m1 : 8'h00;
          s_d.halt = ~cfg.continuous;
          // Too fast a setting drops ticks rather than exceed the top rate
          if (s_q.gap == 16'(MIN_TICK_CLKS - 1)) begin
            s_d.tick = 1'b1;
          end
        end
      end else begin
        s_d.count = s_q.count - 8'h01;
      end
    end else begin
      s_d.presc = s_q.presc - 6'h01;
    end
    // Clocks since the last serial tick, saturating at one below the floor
    if (s_d.tick) begin
      s_d.gap = 16'h0000;
    end else if (s_q.gap != 16'(MIN_TICK_CLKS - 1)) begin
      s_d.gap = s_q.gap + 16'h0001;
    end
    // Transmitter: sixteen ticks per bit
    if (!s_q.tx_busy) begin
      if (tx_req.valid && cfg.serial_en) begin
        s_d.tx_busy = 1'b1;
        s_d.tx_bit = 4'h0;
        s_d.tx_ovs = 4'h0;
        // Stop, stop, eight bit positions, start; LSB out first
        s_d.tx_sh = {2'b11,
                     cfg.parity_en ? odd_par7(tx_req.data[6:0]) : tx_req.data[7],
                     tx_req.data[6:0], 1'b0};
      end
    end else if (s_q.tick) begin
      s_d.tx_ovs = s_q.tx_ovs + 4'h1;
      if (s_q.tx_ovs == 4'(OVS - 1)) begin
        s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
        s_d.tx_bit = s_q.tx_bit + 4'h1;
        if (s_q.tx_bit == 4'(TX_FRAME_BITS - 1)) begin
          s_d.tx_busy = 1'b0;
          s_d.tx_done = 1'b1;
        end
      end
    end
    s_d.tx_o = s_d.tx_busy ? s_d.tx_sh[0] : RST_LINE;
    // Receiver
    if (!cfg.serial_en) begin
      s_d.rx_st = ASPTR_RX_IDLE;
    end else begin
      case (s_q.rx_st)
        ASPTR_RX_IDLE: begin
          if (!s_q.line) begin
            s_d.rx_st = ASPTR_RX_START;
            s_d.rx_ovs = 4'h0;
          end
        end
        ASPTR_RX_START: begin
          if (s_q.tick) begin
            s_d.rx_ovs = s_q.rx_ovs + 4'h1;
            if (s_q.rx_ovs == 4'(OVS_MID)) begin
              // Glitch shorter than half a bit is dropped
              s_d.rx_st = s_q.line ? ASPTR_RX_IDLE : ASPTR_RX_DATA;
              s_d.rx_ovs = 4'h0;
              s_d.rx_bit = 3'h0;
            end
          end
        end
        ASPTR_RX_DATA: begin
          if (s_q.tick) begin
            s_d.rx_ovs = s_q.rx_ovs + 4'h1;
            if (s_q.rx_ovs == 4'(OVS - 1)) begin
              s_d.rx_sh = {s_q.line, s_q.rx_sh[7:1]};
              s_d.rx_bit = s_q.rx_bit + 3'h1;
              if (s_q.rx_bit == 3'(DATA_BITS - 1)) begin
                s_d.rx_st = ASPTR_RX_STOP;
              end
            end
          end
        end
        ASPTR_RX_STOP: begin
          if (s_q.tick) begin
            s_d.rx_ovs = s_q.rx_ovs + 4'h1;
            if (s_q.rx_ovs == 4'(OVS - 1)) begin
              s_d.rx_st = ASPTR_RX_IDLE;
              // Bad stop bit drops the character
              if (s_q.line) begin
                s_d.rx_out.valid = 1'b1;
                s_d.rx_done = 1'b1;
                s_d.rx_out.data = s_q.rx_sh;
                if (cfg.parity_en) begin
                  s_d.rx_out.data[7] = ~(^s_q.rx_sh);
                end
              end
            end
          end
        end
        default: s_d.rx_st = ASPTR_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{sync: 3'h7, line: 1'b1, tx_o: 1'b1, rx_st: ASPTR_RX_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_ready              = ~s_q.tx_busy;
  assign rx_byte               = s_q.rx_out;
  assign transmit_done_request = s_q.tx_done;
  assign receive_done_request  = s_q.rx_done;
  assign port3_out             = {s_q.tx_o, 7'h00};
  assign bit_rate_timer        = s_q.tout;

  // ****************************************
  // Checks
  // ****************************************
  a_tx_one_done: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(s_q.tx_busy) |-> transmit_done_request)
    else $error("transmit request missing at frame end");
  a_tx_start_low: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s_q.tx_busy) |=> !port3_out[PORT_OUT_BIT])
    else $error("start bit not low");
  a_tx_idle_high: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_q.tx_busy && !$past(s_q.tx_busy) |-> port3_out[PORT_OUT_BIT])
    else $error("idle line not high");
  a_rx_done_pair: assert property (@(posedge mclk) disable iff (!rst_n)
    receive_done_request == rx_byte.valid)
    else $error("receive request and valid disagree");
  a_rx_par_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_byte.valid && cfg.parity_en |-> rx_byte.data[7] == ~(^$past(s_q.rx_sh)))
    else $error("parity flag wrong");
  a_tick_rate: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.tick && (MIN_TICK_CLKS > 1) |=> !s_q.tick)
    else $error("tick on adjacent cycles");
  a_tx_not_twice: assert property (@(posedge mclk) disable iff (!rst_n)
    transmit_done_request |=> !transmit_done_request)
    else $error("transmit request repeated");
  a_rx_one_start: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.rx_st == ASPTR_RX_IDLE && s_q.line && cfg.serial_en |=> s_q.rx_st == ASPTR_RX_IDLE)
    else $error("receiver started without a low line");

endmodule

// [sim/asptr_remote.sv]
// Remote serial party facing the timer-paced port.
// Assumes the same mclk and a fixed bit period of BIT clocks.
`timescale 1ns/1ps
module asptr_remote #(
  parameter int BIT = 32
) (
  input  wire logic       mclk,
  input  wire logic       line_in,
  input  wire logic       send,
  input  wire logic [7:0] send_bits,
  input  wire logic [1:0] nstop,
  output logic            line_out,
  output logic            got,
  output logic [9:0]      got_frame
);
  initial begin
    line_out = 1'h1;
    got = 1'h0;
    got_frame = 10'h000;
  end
  // Samples bit centres: eight data, then both stop bits
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(posedge mclk);
      got_frame[i] <= line_in;
    end
    got <= 1'h1;
    @(posedge mclk);
    got <= 1'h0;
  end
  // Start, eight bits LSB first, one or two stops
  always begin
    @(posedge mclk);
    if (send) begin
      line_out <= 1'h0;
      repeat (BIT) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        line_out <= send_bits[i];
        repeat (BIT) @(posedge mclk);
      end
      line_out <= 1'h1;
      repeat (BIT * nstop) @(posedge mclk);
    end
  end
endmodule

// [sim/asptr_serial_tb.sv]
// Self-checking bench for the timer-paced serial port.
// Assumes the remote model on the serial lines; bit = 32 clocks.
`timescale 1ns/1ps
module asptr_serial_tb;
  import asptr_pkg::*;
  localparam int BIT = 32;
  logic        mclk, rst_n, tx_ready, tdr, rdr, tmr, rm_line, rm_send, rm_got;
  asptr_cfg_t  cfg;
  asptr_byte_t tx_req, rx_byte;
  logic [7:0]  p_out, rm_bits, a, b;
  logic [6:0]  noise;
  logic [1:0]  rm_nstop;
  logic [9:0]  rm_frame;
  int          failures, check_count, tx_sent, tx_done, tog;
  int          seed = 32'hE05F;
  logic [9:0]  txq[$];
  logic [7:0]  rxq[$];

  // Rate floor scaled down with the link so that a frame takes a few hundred clocks
  asptr_serial #(.MIN_TICK_CLKS(BIT / OVS)) DUT (.mclk(mclk), .rst_n(rst_n), .cfg(cfg),
    .tx_req(tx_req),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .transmit_done_request(tdr),
    .receive_done_request(rdr), .port3_in({noise, rm_line}), .port3_out(p_out),
    .bit_rate_timer(tmr));
  asptr_remote #(.BIT(BIT)) rm (.mclk(mclk), .line_in(p_out[7]), .send(rm_send),
    .send_bits(rm_bits), .nstop(rm_nstop), .line_out(rm_line), .got(rm_got),
    .got_frame(rm_frame));

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic cmp_frame(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_frame({2'h0, got}, {2'h0, exp});
  endtask
  // Timer output changes seen over forty clocks
  task automatic count_toggles(output int k);
    logic t0;
    k = 0;
    repeat (40) begin
      t0 = tmr;
      @(posedge mclk);
      if (tmr !== t0) k++;
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    if (rm_got) cmp_frame(rm_frame, txq.size() ? txq.pop_front() : ~rm_frame);
    if (tdr) tx_done++;
    if (rx_byte.valid) begin
      cmp_byte({7'h00, rdr}, 8'h01);
      cmp_byte(rx_byte.data, rxq.size() ? rxq.pop_front() : ~rx_byte.data);
    end
  end

  // Second request while busy must be ignored
  task automatic send_tx(input logic [7:0] d, input logic par);
    int n = 0;
    while (!tx_ready && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 4000) begin
      failures++;
      tally_and_finish();
    end else begin
      @(posedge mclk) tx_req <= {1'h1, d};
      txq.push_back({2'h3, par ? {~^d[6:0], d[6:0]} : d});
      @(posedge mclk) tx_req <= {1'h1, ~d};
      @(posedge mclk) tx_req <= 9'h000;
      tx_sent++;
    end
  endtask
  task automatic send_rx(input logic [7:0] d, input logic par);
    @(posedge mclk);
    rm_bits <= d;
    rm_send <= 1'h1;
    rm_nstop <= 2'(1 + ($random(seed) & 1));
    rxq.push_back(par ? {~^d, d[6:0]} : d);
    @(posedge mclk) rm_send <= 1'h0;
    repeat (BIT * 12) @(posedge mclk);
  endtask

  initial begin
    rst_n = 1'h0;
    cfg = '0;
    tx_req = '0;
    rm_send = 1'h0;
    rm_bits = 8'h00;
    rm_nstop = 2'h1;
    noise = 7'h00;
    failures = 0;
    check_count = 0;
    tx_sent = 0;
    tx_done = 0;
    cfg.serial_en = 1'h1;
    cfg.presc_div_m1 = 6'h01;
    cfg.continuous = 1'h1;
    repeat (10) @(posedge mclk);
    cmp_byte(p_out, 8'h80);
    rst_n <= 1'h1;
    // Divide by two, count of one: a change every second clock
    count_toggles(tog);
    cmp_byte(8'(tog), 8'h14);
    for (int p = 0; p < 2; p++) begin
      cfg.parity_en <= p[0];
      for (int i = 0; i < 4; i++) begin
        a = 8'($random(seed));
        b = 8'($random(seed));
        noise <= 7'($random(seed));
        fork
          send_tx(a, p[0]);
          send_rx(b, p[0]);
        join
      end
      repeat (BIT * 4) @(posedge mclk);
      $display("Test parity=%0d done", p);
    end
    // Disabled port must refuse a request
    @(posedge mclk) cfg.serial_en <= 1'h0;
    @(posedge mclk) tx_req <= {1'h1, 8'hA5};
    repeat (BIT * 12) @(posedge mclk);
    tx_req <= 9'h000;
    cmp_byte(tx_done[7:0], tx_sent[7:0]);
    cmp_byte(8'(txq.size() + rxq.size()), 8'h00);
    $display("Test refusal done");
    // Single pass: the timer must stop at its end of count
    cfg.continuous <= 1'h0;
    repeat (8) @(posedge mclk);
    count_toggles(tog);
    cmp_byte(8'(tog), 8'h00);
    cfg.continuous <= 1'h1;
    $display("Test single pass done");
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
endmodule
